// >>> verilog/psc_pkg.sv
/*
 * Shared constants, stage encoding and carrier structs for the passive
 * serial configuration loader.
 * Assumes a 200 MHz system clock that also stands in for the internal
 * initialization oscillator.
 */
package psc_pkg;

	// ------------------------------------------------------------------
	// timing
	// ------------------------------------------------------------------
	localparam int CLOCK_MHZ      = 200;
	localparam int POR_TIME_MS    = 100;
	// longest-style figure: whole cycles, rounded down
	localparam int POR_CYCLES     = POR_TIME_MS * CLOCK_MHZ * 1000;
	localparam int INIT_CYCLES    = 299;
	localparam int ERR_HOLD_TIME_US = 10;
	localparam int ERR_HOLD_CYCLES  = ERR_HOLD_TIME_US * CLOCK_MHZ;

	// ------------------------------------------------------------------
	// widths and defaults
	// ------------------------------------------------------------------
	localparam int CNT_W          = 25;
	localparam int INIT_W         = 9;
	localparam int PIN_W          = 4;
	localparam logic [CNT_W-1:0] DEF_BITSTREAM_BITS = 25'h0002000;
	localparam logic [CNT_W-1:0] DEF_WATCHDOG_CYCLES = 25'h0030d40;
	localparam logic [CNT_W-1:0] CNT_ZERO = 25'h0000000;
	localparam logic [CNT_W-1:0] CNT_ONE  = 25'h0000001;
	localparam logic [INIT_W-1:0] INIT_ZERO = 9'h000;
	localparam logic [INIT_W-1:0] INIT_ONE  = 9'h001;

	// ------------------------------------------------------------------
	// stages
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_POR    = 3'h0,
		ST_RESET  = 3'h1,
		ST_CONFIG = 3'h2,
		ST_INIT   = 3'h3,
		ST_USER   = 3'h4,
		ST_ERROR  = 3'h5
	} stage_t;

	// ------------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------------
	typedef struct packed {
		logic config_request_n;
		logic status;
		logic done;
		logic user_clk;
	} pins_t;

	typedef struct packed {
		logic oe;
		logic out;
	} od_drive_t;

endpackage

// >>> verilog/bit_sync.sv
/*
 * Two-flop level synchroniser, WIDTH bits wide: independent levels (the pins) or a gray-coded word.
 * Assumes each bit is a level or a gray word that changes one bit at a time.
 */
`timescale 1ns/1ps

module bit_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clock,
	input  wire logic             reset_n,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	// ------------------------------------------------------------------
	// stages
	// ------------------------------------------------------------------
	// the first stage feeds nothing but the second
	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] stable_ff;

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			meta_ff   <= '0;
			stable_ff <= '0;
		end else begin
			meta_ff   <= async_in;
			stable_ff <= meta_ff;
		end
	end

	assign sync_out = stable_ff;

endmodule // bit_sync

// >>> verilog/passive_serial_config_loader.sv
/*
 * Passive serial configuration slave: power-on reset, reset / configure /
 * initialize stages, open-drain status and done pins, chain enable in/out,
 * initialization count and user-mode release.
 * Assumes external pull-ups on the status and done wires, a host that
 * owns serial_config_clock, and a testbench that resolves open-drain wires.
 */
`timescale 1ns/1ps

module passive_serial_config_loader
	import psc_pkg::*;
#(
	parameter int               POR_CNT       = POR_CYCLES,
	parameter logic [CNT_W-1:0] STREAM_BITS   = DEF_BITSTREAM_BITS,
	parameter logic [CNT_W-1:0] WATCHDOG_CNT  = DEF_WATCHDOG_CYCLES
) (
	input  wire logic clock,
	input  wire logic reset_n,
	input  wire logic serial_config_clock,
	input  wire logic serial_data_in,
	input  wire logic chain_enable_in_n,
	input  wire logic config_request_n,
	input  wire logic status_in,
	output logic      status_out,
	output logic      status_oe,
	input  wire logic done_in,
	output logic      done_out,
	output logic      done_oe,
	output logic      chain_enable_out_n,
	input  wire logic user_init_clock,
	input  wire logic use_user_clock,
	input  wire logic download_cable_mode,
	input  wire logic auto_restart,
	output logic      user_io_enable,
	output logic      user_mode,
	output logic      config_error,
	output logic      config_bit,
	output logic      config_bit_valid
);

	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------
	function automatic logic [CNT_W-1:0] gray_to_bin(
		input logic [CNT_W-1:0] g
	);
		logic [CNT_W-1:0] b;
		b[CNT_W-1] = g[CNT_W-1];
		for (int i = CNT_W-2; i >= 0; i--) begin
			b[i] = b[i+1] ^ g[i];
		end
		return b;
	endfunction

	// ------------------------------------------------------------------
	// link domain: bit capture
	// ------------------------------------------------------------------
	// the count never clears on this side: the serial clock may stand still,
	// so the system side takes a base snapshot instead of asking for a clear
	logic             ce_meta_ff;
	logic             ce_link_ff;
	logic [CNT_W-1:0] link_bin_ff;
	logic [CNT_W-1:0] link_gray_ff;
	logic             cfg_bit_ff;
	logic             cfg_bit_valid_ff;
	logic [CNT_W-1:0] nxt_link_bin;
	wire              link_take;

	assign link_take    = ~ce_link_ff;
	assign nxt_link_bin = link_bin_ff + CNT_ONE;

	always_ff @(posedge serial_config_clock or negedge reset_n) begin
		if (!reset_n) begin
			ce_meta_ff <= 1'b1;
			ce_link_ff <= 1'b1;
		end else begin
			ce_meta_ff <= chain_enable_in_n;
			ce_link_ff <= ce_meta_ff;
		end
	end

	always_ff @(posedge serial_config_clock or negedge reset_n) begin
		if (!reset_n) begin
			link_bin_ff      <= CNT_ZERO;
			link_gray_ff     <= CNT_ZERO;
			cfg_bit_ff       <= 1'b0;
			cfg_bit_valid_ff <= 1'b0;
		end else begin
			cfg_bit_valid_ff <= link_take;
			if (link_take) begin
				cfg_bit_ff   <= serial_data_in;
				link_bin_ff  <= nxt_link_bin;
				link_gray_ff <= nxt_link_bin ^ (nxt_link_bin >> 1);
			end
		end
	end

	assign config_bit       = cfg_bit_ff;
	assign config_bit_valid = cfg_bit_valid_ff;

	// ------------------------------------------------------------------
	// crossings into the system clock
	// ------------------------------------------------------------------
	pins_t            pins_raw;
	pins_t            pins_s;
	logic [CNT_W-1:0] gray_s;

	assign pins_raw = '{config_request_n: config_request_n,
	                    status:           status_in,
	                    done:             done_in,
	                    user_clk:         user_init_clock};

	bit_sync #(.WIDTH(PIN_W)) u_pin_sync (
		.clock    (clock),
		.reset_n  (reset_n),
		.async_in (pins_raw),
		.sync_out (pins_s)
	);

	bit_sync #(.WIDTH(CNT_W)) u_cnt_sync (
		.clock    (clock),
		.reset_n  (reset_n),
		.async_in (link_gray_ff),
		.sync_out (gray_s)
	);

	// ------------------------------------------------------------------
	// system domain registers
	// ------------------------------------------------------------------
	stage_t           stage_ff;
	stage_t           nxt_stage;
	logic [CNT_W-1:0] por_cnt_ff;
	logic [CNT_W-1:0] base_ff;
	logic [CNT_W-1:0] last_ff;
	logic [CNT_W-1:0] idle_cnt_ff;
	logic [INIT_W-1:0] init_cnt_ff;
	logic             user_d_ff;
	logic             status_oe_ff;
	logic             done_oe_ff;
	logic             ceo_n_ff;
	logic             user_io_ff;
	logic             user_mode_ff;
	logic             error_ff;

	wire [CNT_W-1:0] link_cnt;
	wire [CNT_W-1:0] received;
	wire             por_over;
	wire             hold_reset;
	wire             stream_full;
	wire             bit_seen;
	wire             stalled;
	wire             err_hold_over;
	wire             user_tick;
	wire             user_clk_on;
	wire             init_tick;
	wire             init_over;

	assign link_cnt    = gray_to_bin(gray_s);
	assign received    = link_cnt - base_ff;
	assign bit_seen    = (link_cnt != last_ff);
	assign por_over    = (por_cnt_ff == CNT_W'(POR_CNT - 1));
	assign hold_reset  = ~pins_s.config_request_n | ~pins_s.status;
	assign stream_full = (received >= STREAM_BITS);
	assign stalled     = (received != CNT_ZERO) & ~bit_seen
	                   & (idle_cnt_ff >= WATCHDOG_CNT - CNT_ONE);
	assign err_hold_over = (idle_cnt_ff >= CNT_W'(ERR_HOLD_CYCLES - 1));
	// cable downloads never carry the user clock option
	assign user_clk_on = use_user_clock & ~download_cable_mode;
	assign user_tick   = pins_s.user_clk & ~user_d_ff;
	assign init_tick   = user_clk_on ? user_tick : 1'b1;
	assign init_over   = init_tick
	                   & (init_cnt_ff == INIT_W'(INIT_CYCLES - 1));

	// ------------------------------------------------------------------
	// stage sequencing
	// ------------------------------------------------------------------
	always_comb begin
		nxt_stage = stage_ff;
		case (stage_ff)
			ST_POR: begin
				if (por_over) begin
					nxt_stage = ST_RESET;
				end
			end
			ST_RESET: begin
				if (!hold_reset) begin
					nxt_stage = ST_CONFIG;
				end
			end
			ST_CONFIG: begin
				if (hold_reset) begin
					nxt_stage = ST_RESET;
				end else if (stalled) begin
					nxt_stage = ST_ERROR;
				end else if (stream_full) begin
					nxt_stage = ST_INIT;
				end
			end
			ST_INIT: begin
				if (hold_reset) begin
					nxt_stage = ST_RESET;
				end else if (pins_s.done && init_over) begin
					nxt_stage = ST_USER;
				end
			end
			ST_USER: begin
				if (!pins_s.config_request_n) begin
					nxt_stage = ST_RESET;
				end
			end
			ST_ERROR: begin
				// cable hosts restart by pulsing the request line
				if (!pins_s.config_request_n) begin
					nxt_stage = ST_RESET;
				end else if (err_hold_over && auto_restart
				             && !download_cable_mode) begin
					nxt_stage = ST_RESET;
				end
			end
			default: begin
				nxt_stage = ST_POR;
			end
		endcase
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			stage_ff <= ST_POR;
		end else begin
			stage_ff <= nxt_stage;
		end
	end

	// ------------------------------------------------------------------
	// counters
	// ------------------------------------------------------------------
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			por_cnt_ff <= CNT_ZERO;
		end else if (stage_ff == ST_POR) begin
			por_cnt_ff <= por_cnt_ff + CNT_ONE;
		end
	end

	// base snapshot on entry: bits clocked before the configure stage are dropped
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			base_ff <= CNT_ZERO;
			last_ff <= CNT_ZERO;
		end else begin
			last_ff <= link_cnt;
			if (stage_ff != ST_CONFIG) begin
				base_ff <= link_cnt;
			end
		end
	end

	// idle counter serves the watchdog and the error hold time
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			idle_cnt_ff <= CNT_ZERO;
		end else if (stage_ff != nxt_stage || bit_seen) begin
			idle_cnt_ff <= CNT_ZERO;
		end else if (!idle_cnt_ff[CNT_W-1]) begin
			idle_cnt_ff <= idle_cnt_ff + CNT_ONE;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			init_cnt_ff <= INIT_ZERO;
			user_d_ff   <= 1'b0;
		end else begin
			user_d_ff <= pins_s.user_clk;
			if (stage_ff != ST_INIT || !pins_s.done) begin
				init_cnt_ff <= INIT_ZERO;
			end else if (init_tick && !init_over) begin
				init_cnt_ff <= init_cnt_ff + INIT_ONE;
			end
		end
	end

	// ------------------------------------------------------------------
	// pin drivers
	// ------------------------------------------------------------------
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			status_oe_ff <= 1'b1;
			done_oe_ff   <= 1'b1;
			ceo_n_ff     <= 1'b1;
			user_io_ff   <= 1'b0;
			user_mode_ff <= 1'b0;
			error_ff     <= 1'b0;
		end else begin
			status_oe_ff <= (nxt_stage == ST_POR)
			              | (nxt_stage == ST_ERROR);
			done_oe_ff   <= (nxt_stage != ST_INIT)
			              & (nxt_stage != ST_USER);
			ceo_n_ff     <= (nxt_stage != ST_INIT)
			              & (nxt_stage != ST_USER);
			user_io_ff   <= (nxt_stage == ST_USER);
			user_mode_ff <= (nxt_stage == ST_USER);
			if (nxt_stage == ST_ERROR) begin
				error_ff <= 1'b1;
			end else if (nxt_stage == ST_CONFIG) begin
				error_ff <= 1'b0;
			end
		end
	end

	// open-drain pins only ever pull low
	od_drive_t status_drv;
	od_drive_t done_drv;
	assign status_drv = '{oe: status_oe_ff, out: 1'b0};
	assign done_drv   = '{oe: done_oe_ff,   out: 1'b0};

	assign status_out         = status_drv.out;
	assign status_oe          = status_drv.oe;
	assign done_out           = done_drv.out;
	assign done_oe            = done_drv.oe;
	assign chain_enable_out_n = ceo_n_ff;
	assign user_io_enable     = user_io_ff;
	assign user_mode          = user_mode_ff;
	assign config_error       = error_ff;

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);

	sequence s_enter_user;
		(stage_ff == ST_INIT) ##1 (stage_ff == ST_USER);
	endsequence

	chk_por_hold: assert property (
		(stage_ff == ST_POR) |-> (status_oe && !user_io_enable))
		else $error("status or user pins released during power-on reset");
	chk_por_exit: assert property (
		(stage_ff == ST_POR && por_over) |=> ##1
		(!status_oe && !user_io_enable))
		else $error("status not released after power-on reset");
	chk_reset_hold: assert property (
		(stage_ff == ST_RESET && hold_reset) |=> (stage_ff == ST_RESET))
		else $error("left reset while request or status low");
	chk_cfg_entry: assert property (
		(stage_ff == ST_RESET && !hold_reset) |=>
		(stage_ff == ST_CONFIG) ##1 !status_oe)
		else $error("configuration not entered or status still driven");
	chk_stage_order: assert property (
		(stage_ff == ST_INIT) |-> $past(stage_ff) inside {ST_CONFIG, ST_INIT})
		else $error("initialization not preceded by configuration");
	chk_done_rise: assert property (
		(stage_ff == ST_CONFIG && !hold_reset && !stalled && stream_full)
		|=> (!done_oe && !chain_enable_out_n))
		else $error("done or chain enable not released after last bit");
	chk_init_wait: assert property (
		(stage_ff == ST_INIT && !pins_s.done) |-> (init_cnt_ff == INIT_ZERO))
		else $error("initialization counted before shared done high");
	chk_init_count: assert property (
		s_enter_user |-> ($past(init_cnt_ff) == INIT_W'(INIT_CYCLES - 1)))
		else $error("user mode entered without full initialization count");
	chk_user_pins: assert property (
		s_enter_user |=> (user_io_enable && user_mode))
		else $error("user pins not enabled on entering user mode");
	chk_status_err: assert property (
		(stage_ff inside {ST_CONFIG, ST_INIT} && !pins_s.status)
		|=> (stage_ff == ST_RESET))
		else $error("status low did not halt configuration");
	chk_error_pull: assert property (
		(stage_ff == ST_ERROR && nxt_stage == ST_ERROR) |-> status_oe[*2])
		else $error("error stage did not hold status low");
	chk_cable_restart: assert property (
		(stage_ff == ST_ERROR && download_cable_mode
		 && pins_s.config_request_n) |=> (stage_ff == ST_ERROR))
		else $error("cable mode restarted without request pulse");

	chk_link_gate: assert property (
		@(posedge serial_config_clock) disable iff (!reset_n)
		ce_link_ff |=> $stable(link_bin_ff))
		else $error("bit counted while chain enable high");

endmodule // passive_serial_config_loader

// >>> verif/ps_host_model.sv
/*
 * Behavioural host for the passive serial loader: request line, serial
 * clock and data, and a pull on the shared status wire.
 * Assumes the bench resolves the open-drain status and done wires.
 */
`timescale 1ns/1ps

module ps_host_model (
	output logic      serial_config_clock,
	output logic      serial_data_in,
	output logic      config_request_n,
	output logic      status_pull,
	input  wire logic status_wire
);
	logic last_bit;

	initial begin
		serial_config_clock = 1'b0;
		serial_data_in      = 1'b1;
		config_request_n    = 1'b0;
		status_pull         = 1'b0;
		last_bit            = 1'b0;
	end

	// --------------------------------------------------------------
	// request and status
	// --------------------------------------------------------------
	// the host request restarts the device after an error, as does auto restart outside cable mode
	task automatic set_req(input logic v);
		config_request_n = v;
	endtask

	// master pulls the shared status low to reset the whole chain
	task automatic pull(input logic v);
		status_pull = v;
	endtask

	// --------------------------------------------------------------
	// serial frame
	// --------------------------------------------------------------
	// clock period is 12 ns plus the gap, and stands low outside frames
	task automatic send(input logic [31:0] bits, input int n,
		input int gap);
		int w;
		w = 0;
		while (status_wire !== 1'b1 && w < 2000) begin
			#1;
			w++;
		end
		for (int i = 0; i < n; i++) begin
			serial_data_in = bits[i];
			last_bit = bits[i];
			#6;
			serial_config_clock = 1'b1;
			#6;
			serial_config_clock = 1'b0;
			#(gap);
		end
		// released data line must not look like a held bit
		serial_data_in = ~last_bit;
	endtask
endmodule // ps_host_model

// >>> verif/tb_passive_serial_config_loader.sv
/*
 * Self-checking bench for the passive serial configuration loader.
 * Assumes shortened counts (20 power-on cycles, 16 bits, watchdog 50)
 * and resolves the open-drain status and done wires itself.
 */
`timescale 1ns/1ps

module tb_passive_serial_config_loader
	import psc_pkg::*;
;
	localparam int NB = 16;

	logic clock, reset_n, chain_enable_in_n, use_user_clock;
	logic download_cable_mode, auto_restart, uclk_en, other_done_pull;
	logic status_oe, status_out, done_oe, done_out, chain_enable_out_n;
	logic user_io_enable, user_mode, config_error, config_bit;
	logic config_bit_valid, serial_config_clock, serial_data_in;
	logic config_request_n, status_pull, status_w, done_w;
	logic       user_init_clock = 1'b0;
	logic [2:0] ucnt            = 3'h0;
	int         n_fail          = 0;
	int         checks          = 0;
	int         cycles          = 0;
	int         seed;

	initial clock = 1'b0;
	always #2.5 clock = ~clock;

	assign status_w = (status_oe ? status_out : 1'b1) & ~status_pull;
	assign done_w   = (done_oe ? done_out : 1'b1) & ~other_done_pull;

	passive_serial_config_loader #(
		.POR_CNT      (20),
		.STREAM_BITS  (25'h0000010),
		.WATCHDOG_CNT (25'h0000032)
	) dut_u (
		.clock               (clock),
		.reset_n             (reset_n),
		.serial_config_clock (serial_config_clock),
		.serial_data_in      (serial_data_in),
		.chain_enable_in_n   (chain_enable_in_n),
		.config_request_n    (config_request_n),
		.status_in           (status_w),
		.status_out          (status_out),
		.status_oe           (status_oe),
		.done_in             (done_w),
		.done_out            (done_out),
		.done_oe             (done_oe),
		.chain_enable_out_n  (chain_enable_out_n),
		.user_init_clock     (user_init_clock),
		.use_user_clock      (use_user_clock),
		.download_cable_mode (download_cable_mode),
		.auto_restart        (auto_restart),
		.user_io_enable      (user_io_enable),
		.user_mode           (user_mode),
		.config_error        (config_error),
		.config_bit          (config_bit),
		.config_bit_valid    (config_bit_valid)
	);

	ps_host_model host_u (
		.serial_config_clock (serial_config_clock),
		.serial_data_in      (serial_data_in),
		.config_request_n    (config_request_n),
		.status_pull         (status_pull),
		.status_wire         (status_w)
	);

	// user clock runs at one eighth of the system clock
	always @(posedge clock) begin
		ucnt <= ucnt + 3'h1;
		user_init_clock <= #1 uclk_en & ucnt[2];
	end

	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_fail++;
			finish_test();
		end
	end

	// --------------------------------------------------------------
	// helpers
	// --------------------------------------------------------------
	task automatic chk(input logic got, input logic exp, input string w);
		checks++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %0t ns %s got %b exp %b", $time, w, got, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask

	function automatic logic pick(input int s);
		case (s)
			0: pick = status_oe;
			1: pick = done_w;
			2: pick = user_mode;
			3: pick = done_oe;
			default: pick = status_w;
		endcase
	endfunction

	function automatic int init_wait(input logic u);
		return u ? INIT_CYCLES * 8 : INIT_CYCLES;
	endfunction

	// bounded wait, then the level itself is compared
	task automatic wait_sig(input int s, input logic v, input int lim);
		int n;
		n = 0;
		while (pick(s) !== v && n < lim) begin
			@(posedge clock);
			#1;
			n++;
		end
		chk(pick(s), v, "wait");
	endtask

	task automatic end_test(input string name);
		$display("test %s done", name);
	endtask

	task automatic restart();
		host_u.set_req(1'b0);
		cyc(4);
		chk(user_mode, 1'b0, "request low");
		host_u.set_req(1'b1);
		wait_sig(4, 1'b1, 20);
		// let the synced request reach the stage before the first bit
		cyc(4);
	endtask

	// bits sent in reset are refused, and they settle the enable sync
	task automatic prime(input logic ce_n);
		host_u.set_req(1'b0);
		chain_enable_in_n = ce_n;
		cyc(2);
		host_u.send($urandom, 4, 0);
		cyc(6);
		chk(done_oe, 1'b1, "reset bits");
		restart();
	endtask

	task automatic frame(input int n, input logic look);
		logic [31:0] b;
		b = $urandom;
		host_u.send(b, n, $urandom_range(0, 60));
		cyc(2);
		if (look)
			chk(config_bit, b[n-1], "last bit");
		chk(config_bit_valid, look, "bit valid");
	endtask

	task automatic init_check(input logic u);
		wait_sig(3, 1'b0, 12);
		chk(chain_enable_out_n, 1'b0, "chain out");
		wait_sig(1, 1'b1, 4);
		cyc(init_wait(u) - 10);
		chk(user_mode, 1'b0, "early user");
		wait_sig(2, 1'b1, 40);
		chk(user_io_enable, 1'b1, "pins");
	endtask

	task automatic finish_test();
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// --------------------------------------------------------------
	// tests
	// --------------------------------------------------------------
	initial begin
		seed = $urandom(32'h2a0a);
		reset_n = 1'b0;
		chain_enable_in_n = 1'b0;
		use_user_clock = 1'b0;
		// neither matters until the first error is provoked
		download_cable_mode = 1'($urandom_range(0, 1));
		auto_restart = 1'($urandom_range(0, 1));
		uclk_en = 1'b0;
		other_done_pull = 1'b0;
		cyc(10);
		chk(status_oe, 1'b1, "por status");
		chk(user_io_enable, 1'b0, "por pins");
		reset_n = 1'b1;
		cyc(19);
		chk(status_oe, 1'b1, "por hold");
		wait_sig(0, 1'b0, 8);
		chk(user_io_enable, 1'b0, "pins after por");
		end_test("por");

		other_done_pull = 1'b1;
		prime(1'b0);
		frame(NB - 1, 1'b1);
		cyc(10);
		chk(done_oe, 1'b1, "early done");
		frame(1, 1'b1);
		wait_sig(3, 1'b0, 12);
		cyc(400);
		chk(user_mode, 1'b0, "shared done");
		other_done_pull = 1'b0;
		init_check(1'b0);
		end_test("config");

		prime(1'b1);
		frame(NB, 1'b0);
		cyc(10);
		chk(done_oe, 1'b1, "disabled");
		prime(1'b0);
		frame(NB, 1'b1);
		init_check(1'b0);
		end_test("chain");

		restart();
		frame(8, 1'b1);
		host_u.pull(1'b1);
		cyc(5);
		host_u.pull(1'b0);
		frame(10, 1'b1);
		cyc(10);
		chk(done_oe, 1'b1, "pulled");
		frame(NB - 10, 1'b1);
		init_check(1'b0);
		end_test("status pull");

		auto_restart = 1'b1;
		download_cable_mode = 1'b0;
		restart();
		frame(3, 1'b1);
		cyc(60);
		chk(status_oe, 1'b1, "stall");
		chk(config_error, 1'b1, "error");
		cyc(ERR_HOLD_CYCLES - 120);
		chk(status_oe, 1'b1, "hold");
		wait_sig(0, 1'b0, 300);
		cyc(6);
		chk(config_error, 1'b0, "error clear");
		frame(NB, 1'b1);
		init_check(1'b0);
		end_test("auto restart");

		download_cable_mode = 1'b1;
		use_user_clock = 1'($urandom_range(0, 1));
		auto_restart = 1'($urandom_range(0, 1));
		restart();
		frame(3, 1'b1);
		cyc(ERR_HOLD_CYCLES + 260);
		chk(status_oe, 1'b1, "cable error");
		restart();
		frame(NB, 1'b1);
		init_check(1'b0);
		end_test("cable");

		download_cable_mode = 1'b0;
		use_user_clock = 1'b1;
		uclk_en = 1'b1;
		restart();
		frame(NB, 1'b1);
		init_check(1'b1);
		end_test("user clock");
		finish_test();
	end
endmodule // tb_passive_serial_config_loader
